//--- analog_front_model.sv
// Sample-and-hold comparator standing for the analog front end.
`timescale 1ns/100ps
module analog_front_model (
  input wire logic clk_i,
  input wire logic sample_i,
  input wire logic [9:0] level_i,
  input wire logic [9:0] dac_code_i,
  output logic comp_o
);
  logic [9:0] held = 10'h000;
  // The level is frozen when sampling ends, so later input changes
  // cannot disturb a conversion that is already resolving.
  always_ff @(posedge clk_i)
  begin
    if (sample_i)
    begin
      held <= level_i;
    end
  end
  assign comp_o = (held >= dac_code_i);
endmodule

//--- clock_prescaler.sv
// Divider that turns the source clock enable into converter clock ticks.
`timescale 1ns/100ps
`include "sar_adc_params.svh"
module clock_prescaler (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic src_tick_i,
  input wire logic [2:0] prescale_i,
  output logic tick_o
);
  import sar_adc_pkg::*;
  logic [3:0] count;
  logic [3:0] last;

  always_comb
  begin
    if (prescale_i[2])
      last = `DIV16_LAST; // [RL26]
    else
      last = 4'(4'h1 << prescale_i[1:0]) - 4'h1; // [RL26]
  end

  // The counter is never restarted by a conversion start, so the first
  // period after a start is usually partial. [RL9]
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      count <= 4'h0;
      tick_o <= 1'b0;
    end
    else
    begin
      tick_o <= src_tick_i && (count >= last); // [RL8]
      if (src_tick_i)
        count <= (count >= last) ? 4'h0 : count + 4'h1;
    end
  end
endmodule

//--- sar_adc_monitor.sv
// Checker on the ports of the converter control top.
`timescale 1ns/100ps
module sar_adc_monitor #(
  parameter int CHANNELS = 10
) (
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic pready_o,
  input wire logic [CHANNELS-1:0] port_out_i,
  input wire logic [CHANNELS-1:0] port_dir_i,
  input wire logic [CHANNELS-1:0] pin_in_i,
  input wire logic [CHANNELS-1:0] pin_out_o,
  input wire logic [CHANNELS-1:0] pin_oe_o,
  input wire logic [CHANNELS-1:0] port_read_o,
  input wire logic [CHANNELS-1:0] pin_takeover_o,
  input wire logic [4:0] analog_channel_o,
  input wire logic power_down_o,
  input wire logic sample_o,
  input wire logic irq_o
);
  logic [CHANNELS-1:0] dir_q;
  logic [CHANNELS-1:0] out_q;
  logic [CHANNELS-1:0] in_q;
  logic [CHANNELS-1:0] tk_q;
  logic [CHANNELS-1:0] exp_tk;
  logic [4:0] ch_q;
  logic [2:0] live;
  logic calm;
  logic calm_q;
  logic settled;
  logic done;
  ////////////////////////////////////////
  // Pin outputs are registered behind the channel, so they are judged
  // only once inputs and channel have sat still for two cycles.
  assign calm = live[2] && dir_q == port_dir_i && out_q == port_out_i &&
    in_q == pin_in_i && ch_q == analog_channel_o && tk_q == pin_takeover_o;
  assign settled = calm && calm_q;
  assign done = psel_i && penable_i && pready_o;
  assign exp_tk = (analog_channel_o < CHANNELS) ?
    (CHANNELS'(1) << analog_channel_o) : '0;
  always_ff @(posedge ref_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      live <= 3'h0;
      calm_q <= 1'b0;
    end
    else
    begin
      live <= {live[1:0], 1'b1};
      calm_q <= calm;
    end
  end
  always_ff @(posedge ref_clk_i)
  begin
    dir_q <= port_dir_i;
    out_q <= port_out_i;
    in_q <= pin_in_i;
    tk_q <= pin_takeover_o;
    ch_q <= analog_channel_o;
  end
  ////////////////////////////////////////
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!reset_n_i);
  one_pin_a: assert property ($onehot0(pin_takeover_o))
    else $error("more than one pin taken");
  takeover_sel_a: assert property (
    settled |-> pin_takeover_o == exp_tk)
    else $error("taken pin differs from channel");
  pin_oe_a: assert property (
    settled |-> pin_oe_o == (port_dir_i & ~pin_takeover_o))
    else $error("pin enable wrong");
  pin_out_a: assert property (
    settled |-> pin_out_o == (port_out_i & ~pin_takeover_o))
    else $error("pin drive wrong");
  port_read_a: assert property (
    settled |-> port_read_o == (pin_in_i & ~pin_takeover_o))
    else $error("port read not masked");
  power_off_a: assert property (
    settled |-> power_down_o == (analog_channel_o == 5'h1f))
    else $error("power down wrong");
  write_start_a: assert property (
    done && pwrite_i && paddr_i == 8'h00 && pwdata_i[4:0] != 5'h1f
    |-> ##[1:900] sample_o)
    else $error("no sampling after control write");
  irq_clear_a: assert property (
    done && (pwrite_i ? paddr_i == 8'h00 :
    (paddr_i == 8'h04 || paddr_i == 8'h08)) |=> !irq_o)
    else $error("interrupt not cleared");
endmodule

bind sar_adc_top sar_adc_monitor #(.CHANNELS(CHANNELS)) mon_u (.*);

//--- sar_adc_params.svh
// Constants for the successive-approximation converter control block.
// Summary of operation
// RL1: Multiplexer routes exactly one of ten external channels to the converter.
// RL2: The selected shared pin is taken from port logic; others stay ported.
// RL3: Port output and direction writes never affect the selected pin.
// RL4: Port reads of the selected pin return zero.
// RL5: Result saturates at all ones or zeros beyond references, linear between.
// RL6: Any write of the status and control register starts a conversion; a write of the power-off code stops it instead.
// RL7: A conversion takes 16 or 17 converter clock periods.
// RL8: Converter clock is bus or crystal clock, chosen by select bit, prescaled.
// RL9: The unaligned start gives a partial first period, the seventeenth cycle.
// RL10: Continuous mode overwrites results even when software has not read them.
// RL11: Continuous bit restarts conversions after each completion until cleared.
// RL12: Without interrupts the complete flag sets and holds until a result read.
// RL13: Software discards a result if it rewrote control mid-conversion.
// RL14: Four result formats are selected by a two-bit mode field.
// RL15: Left justified puts eight high bits high and two low bits low.
// RL16: After a high read, low value holds and new results are refused.
// RL17: Right justified puts two top bits high, eight low bits low.
// RL18: Signed left justified inverts result bit nine in the high register.
// RL19: Eight-bit mode puts top eight bits low, no interlock.
// RL20: With interrupts enabled completion requests an interrupt; flag reads zero.
// RL21: Converter runs on in wait mode; its interrupt can wake the processor.
// RL22: Software powers the converter down before wait if wake-up is unneeded.
// RL23: Writing status and control aborts the running conversion and restarts; a write of the power-off code only aborts.
// RL24: A result read or control write clears the pending interrupt.
// RL25: All-ones channel code powers off; recovery costs one conversion period.
// RL26: Prescale codes zero to three divide by 1,2,4,8; top bit gives 16.
// RL27: Mode codes zero to three: left, right, signed left, eight-bit.
// RL28: Sequencer resolves one bit per converter clock from the top bit down.
`ifndef SAR_ADC_PARAMS_SVH
`define SAR_ADC_PARAMS_SVH
`define OFS_STATUS_CONTROL 8'h00
`define OFS_RESULT_HIGH 8'h04
`define OFS_RESULT_LOW 8'h08
`define OFS_CLOCK_CONFIG 8'h0C
`define SCR_CONV_COMPLETE_FLAG_BIT 7
`define SCR_IRQ_EN_BIT 6
`define SCR_CONT_BIT 5
`define SCR_CHAN_MSB 4
`define CLK_DIV_MSB 7
`define CLK_DIV_LSB 5
`define CLK_SEL_BIT 4
`define CLK_MODE_MSB 3
`define CLK_MODE_LSB 2
`define CHAN_POWER_OFF 5'h1F
`define CHAN_RESET 5'h1F
`define CLK_CONFIG_RESET 8'h00
`define SAMPLE_TICKS 6'h06
`define WARM_TICKS 6'h10
`define DIV16_LAST 4'hF
`endif

//--- sar_adc_pkg.sv
// Types shared by the converter control modules.
package sar_adc_pkg;
  typedef enum logic [2:0] {
    seq_idle = 3'b001,
    seq_sample = 3'b010,
    seq_resolve = 3'b100
  } seq_state_type;
  typedef enum logic [1:0] {
    fmt_left = 2'h0,
    fmt_right = 2'h1,
    fmt_signed = 2'h2,
    fmt_trunc8 = 2'h3
  } format_type;
endpackage

//--- sar_adc_top.sv
// Converter control top: APB registers, pin takeover, formatting, flags.
`timescale 1ns/100ps
`include "sar_adc_params.svh"
module sar_adc_top #(
  parameter int CHANNELS = 10,
  parameter int RES_BITS = 10
) (
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic crystal_tick_i,
  input wire logic comparator_i,
  input wire logic [CHANNELS-1:0] port_out_i,
  input wire logic [CHANNELS-1:0] port_dir_i,
  input wire logic [CHANNELS-1:0] pin_in_i,
  output logic [CHANNELS-1:0] pin_out_o,
  output logic [CHANNELS-1:0] pin_oe_o,
  output logic [CHANNELS-1:0] port_read_o,
  output logic [CHANNELS-1:0] pin_takeover_o,
  output logic [4:0] analog_channel_o,
  output logic power_down_o,
  output logic sample_o,
  output logic [RES_BITS-1:0] dac_code_o,
  output logic irq_o
);
  import sar_adc_pkg::*;

  generate
    if (CHANNELS < 1 || CHANNELS > 10)
      $error("sar_adc_top: CHANNELS must be 1 to 10");
    if (RES_BITS != 10)
      $error("sar_adc_top: result formats need RES_BITS of 10");
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Reset release.

  logic rst_meta;
  logic rst_n;

  always_ff @(posedge ref_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end
    else
    begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB slave. The answer takes one wait state so that read data and the
  // error flag come from flip-flops.

  logic access;
  logic wr_fire;
  logic rd_fire;
  logic wr_scr;
  logic wr_clk;
  logic rd_high;
  logic rd_low;
  logic mapped;

  assign access = psel_i && penable_i;
  assign wr_fire = access && pready_o && pwrite_i;
  assign rd_fire = access && pready_o && !pwrite_i;
  assign wr_scr = wr_fire && (paddr_i == `OFS_STATUS_CONTROL);
  assign wr_clk = wr_fire && (paddr_i == `OFS_CLOCK_CONFIG);
  assign rd_high = rd_fire && (paddr_i == `OFS_RESULT_HIGH);
  assign rd_low = rd_fire && (paddr_i == `OFS_RESULT_LOW);
  assign mapped = (paddr_i == `OFS_STATUS_CONTROL) ||
                  (paddr_i == `OFS_RESULT_HIGH) ||
                  (paddr_i == `OFS_RESULT_LOW) ||
                  (paddr_i == `OFS_CLOCK_CONFIG);

  always_ff @(posedge ref_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
    end
    else
    begin
      pready_o <= access && !pready_o;
      pslverr_o <= access && !pready_o && !mapped;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control registers.

  logic irq_en;
  logic cont;
  logic [4:0] channel;
  logic [2:0] prescale;
  logic clk_sel;
  format_type mode;
  logic off_sel;
  localparam logic [7:0] CLK_CFG_INIT = `CLK_CONFIG_RESET;

  assign off_sel = (pwdata_i[`SCR_CHAN_MSB:0] == `CHAN_POWER_OFF);

  always_ff @(posedge ref_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      irq_en <= 1'b0;
      cont <= 1'b0;
      channel <= `CHAN_RESET;
    end
    else if (wr_scr)
    begin
      irq_en <= pwdata_i[`SCR_IRQ_EN_BIT];
      cont <= pwdata_i[`SCR_CONT_BIT];
      channel <= pwdata_i[`SCR_CHAN_MSB:0];
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      prescale <= CLK_CFG_INIT[`CLK_DIV_MSB:`CLK_DIV_LSB];
      clk_sel <= CLK_CFG_INIT[`CLK_SEL_BIT];
      mode <= format_type'(CLK_CFG_INIT[`CLK_MODE_MSB:`CLK_MODE_LSB]);
    end
    else if (wr_clk)
    begin
      prescale <= pwdata_i[`CLK_DIV_MSB:`CLK_DIV_LSB];
      clk_sel <= pwdata_i[`CLK_SEL_BIT];
      mode <= format_type'(pwdata_i[`CLK_MODE_MSB:`CLK_MODE_LSB]); // [RL14]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Converter clock and sequencer.

  sar_link_if #(.RES_BITS(RES_BITS)) link ();
  logic src_tick;
  logic start;
  logic stop;
  logic was_off;

  // A clock select of one means bus clock; reset leaves the crystal clock.
  assign src_tick = clk_sel ? 1'b1 : crystal_tick_i; // [RL8]

  clock_prescaler prescaler (
    .clk_i(ref_clk_i),
    .rst_n_i(rst_n),
    .src_tick_i(src_tick),
    .prescale_i(prescale),
    .tick_o(link.tick)
  );

  sar_sequencer #(.RES_BITS(RES_BITS)) sequencer (
    .clk_i(ref_clk_i),
    .rst_n_i(rst_n),
    .link(link)
  );

  always_ff @(posedge ref_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      start <= 1'b0;
      stop <= 1'b0;
      was_off <= 1'b1;
    end
    else
    begin
      // Any write restarts; the power-off code stops instead. [RL6] [RL23]
      start <= (wr_scr && !off_sel) ||
               (link.done && cont && channel != `CHAN_POWER_OFF); // [RL11]
      stop <= wr_scr && off_sel; // [RL25]
      if (wr_scr && off_sel)
        was_off <= 1'b1;
      else if (start)
        was_off <= 1'b0;
    end
  end

  assign link.start = start;
  assign link.stop = stop;
  // The first conversion after power-off gets an extra settling period.
  assign link.warm = was_off; // [RL25]
  assign link.comp = comparator_i;
  assign sample_o = link.sampling;
  assign dac_code_o = link.dac_code;

  ////////////////////////////////////////////////////////////////////////////
  // Result formatting and the high/low read interlock.

  logic [7:0] result_high_reg;
  logic [7:0] result_low_reg;
  logic locked;
  logic [RES_BITS-1:0] r;

  assign r = link.result;

  always_ff @(posedge ref_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      result_high_reg <= 8'h00;
      result_low_reg <= 8'h00;
    end
    // Storing is refused while a high read waits for its low read. [RL16]
    else if (link.done && (!locked || mode == fmt_trunc8)) // [RL10]
    begin
      case (mode) // [RL27]
        fmt_left:
        begin
          result_high_reg <= r[9:2]; // [RL15]
          result_low_reg <= {r[1:0], 6'h00}; // [RL15]
        end
        fmt_right:
        begin
          result_high_reg <= {6'h00, r[9:8]}; // [RL17]
          result_low_reg <= r[7:0]; // [RL17]
        end
        fmt_signed:
        begin
          result_high_reg <= {~r[9], r[8:2]}; // [RL18]
          result_low_reg <= {r[1:0], 6'h00};
        end
        fmt_trunc8:
        begin
          result_high_reg <= 8'h00;
          result_low_reg <= r[9:2]; // [RL19]
        end
        default:
        begin
          result_high_reg <= r[9:2];
          result_low_reg <= {r[1:0], 6'h00};
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n)
  begin
    if (!rst_n)
      locked <= 1'b0;
    else if (rd_low || mode == fmt_trunc8)
      locked <= 1'b0; // [RL19]
    else if (rd_high)
      locked <= 1'b1; // [RL16]
  end

  ////////////////////////////////////////////////////////////////////////////
  // Completion flag and interrupt request. A completion in the same cycle
  // as a clearing access wins, so no event is lost.

  logic conv_complete_flag;

  always_ff @(posedge ref_clk_i or negedge rst_n)
  begin
    if (!rst_n)
      conv_complete_flag <= 1'b0;
    else if (link.done && !irq_en)
      conv_complete_flag <= 1'b1; // [RL12]
    else if (rd_high || rd_low || irq_en)
      conv_complete_flag <= 1'b0; // [RL12] [RL20]
  end

  // The request runs on the system clock, so it keeps working while the
  // processor waits and can wake it. [RL21]
  always_ff @(posedge ref_clk_i or negedge rst_n)
  begin
    if (!rst_n)
      irq_o <= 1'b0;
    else if (link.done && irq_en)
      irq_o <= 1'b1; // [RL20]
    else if (rd_high || rd_low || wr_scr)
      irq_o <= 1'b0; // [RL24]
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register read data.

  always_ff @(posedge ref_clk_i or negedge rst_n)
  begin
    if (!rst_n)
      prdata_o <= 32'h0000_0000;
    else if (access && !pready_o)
    begin
      case (paddr_i)
        `OFS_STATUS_CONTROL:
          prdata_o <= {24'h00_0000, conv_complete_flag, irq_en, cont, channel};
        `OFS_RESULT_HIGH:
          prdata_o <= {24'h00_0000, result_high_reg};
        `OFS_RESULT_LOW:
          prdata_o <= {24'h00_0000, result_low_reg};
        `OFS_CLOCK_CONFIG:
          prdata_o <= {24'h00_0000, prescale, clk_sel, mode, 2'h0};
        default:
          prdata_o <= 32'h0000_0000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Channel selection and shared pin takeover.

  logic [CHANNELS-1:0] sel_mask;

  always_comb
  begin
    sel_mask = '0;
    for (int i = 0; i < CHANNELS; i++)
      if (channel == 5'(i))
        sel_mask[i] = 1'b1; // [RL1]
  end

  always_ff @(posedge ref_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pin_out_o <= '0;
      pin_oe_o <= '0;
      port_read_o <= '0;
      pin_takeover_o <= '0;
      analog_channel_o <= `CHAN_RESET;
      power_down_o <= 1'b1;
    end
    else
    begin
      pin_takeover_o <= sel_mask; // [RL2]
      // The selected pin is input-only whatever the port logic asks.
      pin_out_o <= port_out_i & ~sel_mask; // [RL3]
      pin_oe_o <= port_dir_i & ~sel_mask; // [RL2] [RL3]
      port_read_o <= pin_in_i & ~sel_mask; // [RL4]
      analog_channel_o <= channel; // [RL1]
      power_down_o <= (channel == `CHAN_POWER_OFF); // [RL25]
    end
  end
endmodule

//--- sar_link_if.sv
// Signals between the control registers and the sequencer.
`timescale 1ns/100ps
interface sar_link_if #(parameter int RES_BITS = 10);
  logic start;
  logic stop;
  logic warm;
  logic tick;
  logic comp;
  logic done;
  logic sampling;
  logic [RES_BITS-1:0] dac_code;
  logic [RES_BITS-1:0] result;
  modport seq (input start, stop, warm, tick, comp,
               output done, sampling, dac_code, result);
  modport ctrl (output start, stop, warm, tick, comp,
                input done, sampling, dac_code, result);
endinterface

//--- sar_sequencer.sv
// Successive-approximation sequencer: sample phase, then one bit per tick.
`timescale 1ns/100ps
`include "sar_adc_params.svh"
module sar_sequencer #(
  parameter int RES_BITS = 10
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  sar_link_if.seq link
);
  import sar_adc_pkg::*;
  localparam int POS_W = $clog2(RES_BITS);
  seq_state_type state;
  logic [5:0] count;
  logic [5:0] sample_len;
  logic [POS_W-1:0] bit_pos;
  logic [RES_BITS-1:0] next_dac;

  generate
    if (RES_BITS < 2 || RES_BITS > 16)
      $error("sar_sequencer: RES_BITS must be 2 to 16");
  endgenerate

  always_comb
  begin
    next_dac = link.dac_code;
    next_dac[bit_pos] = link.comp; // [RL5]
    if (bit_pos != '0)
      next_dac[bit_pos - 1'b1] = 1'b1;
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      state <= seq_idle;
      count <= 6'h00;
      sample_len <= `SAMPLE_TICKS;
      bit_pos <= '0;
      link.dac_code <= '0;
      link.result <= '0;
      link.done <= 1'b0;
      link.sampling <= 1'b0;
    end
    else
    begin
      link.done <= 1'b0;
      if (link.stop)
      begin
        state <= seq_idle;
        link.sampling <= 1'b0;
      end
      else if (link.start)
      begin
        // A start while busy simply restarts, which is the abort. [RL23]
        state <= seq_sample;
        count <= 6'h00;
        sample_len <= link.warm ? `SAMPLE_TICKS + `WARM_TICKS
                                : `SAMPLE_TICKS; // [RL25]
        link.dac_code <= '0;
        link.sampling <= 1'b1;
      end
      else
      begin
        case (state)
          seq_idle:
            link.sampling <= 1'b0;
          seq_sample:
            if (link.tick)
            begin
              // The first tick only closes the partial period. [RL9]
              if (count == sample_len)
              begin
                state <= seq_resolve;
                link.sampling <= 1'b0;
                bit_pos <= POS_W'(RES_BITS - 1);
                link.dac_code <= '0;
                link.dac_code[RES_BITS-1] <= 1'b1; // [RL28]
              end
              else
                count <= count + 6'h01;
            end
          seq_resolve:
            if (link.tick)
            begin
              link.dac_code <= next_dac; // [RL28]
              if (bit_pos == '0)
              begin
                state <= seq_idle;
                link.result <= next_dac;
                link.done <= 1'b1; // [RL7]
              end
              else
                bit_pos <= bit_pos - 1'b1;
            end
          default:
            state <= seq_idle;
        endcase
      end
    end
  end
endmodule

//--- tb_top.sv
// Self-checking testbench for the converter control top.
`timescale 1ns/100ps
module tb_top;
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic xtal = 1'b0;
  logic [1:0] xdiv = 2'h0;
  logic comp;
  logic [9:0] port_out = 10'h000;
  logic [9:0] port_dir = 10'h000;
  logic [9:0] pin_in = 10'h000;
  logic [9:0] pin_out;
  logic [9:0] pin_oe;
  logic [9:0] port_read;
  logic [9:0] takeover;
  logic [4:0] achan;
  logic pdown;
  logic sample;
  logic [9:0] dac;
  logic irq;
  logic [9:0] level = 10'h000;
  logic [15:0] lfsr = 16'h003f;
  int err_total = 0;
  int num_checks = 0;
  ////////////////////////////////////////
  sar_adc_top dut_u (.ref_clk_i(ref_clk), .reset_n_i(reset_n),
    .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
    .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .crystal_tick_i(xtal),
    .comparator_i(comp), .port_out_i(port_out), .port_dir_i(port_dir),
    .pin_in_i(pin_in), .pin_out_o(pin_out), .pin_oe_o(pin_oe),
    .port_read_o(port_read), .pin_takeover_o(takeover),
    .analog_channel_o(achan), .power_down_o(pdown), .sample_o(sample),
    .dac_code_o(dac), .irq_o(irq));
  analog_front_model front_u (.clk_i(ref_clk), .sample_i(sample),
    .level_i(level), .dac_code_i(dac), .comp_o(comp));
  initial
  begin
    forever #50 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk)
  begin
    xdiv <= (xdiv == 2'h2) ? 2'h0 : xdiv + 2'h1;
    xtal <= (xdiv == 2'h2);
  end
  ////////////////////////////////////////
  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function automatic logic [15:0] fmt_exp(input logic [1:0] f,
    input logic [9:0] r);
    case (f)
      2'h0: return {r, 6'h00};
      2'h1: return {6'h00, r};
      2'h2: return {~r[9], r[8:0], 6'h00};
      default: return {8'h00, r[9:2]};
    endcase
  endfunction
  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] exp,
    input string what);
    num_checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("[ERR] %0t %s: got %h want %h", $time, what, seen, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
    input logic [7:0] d, output logic [7:0] q, output logic e);
    int n;
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h00_0000, d};
    @(posedge ref_clk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge ref_clk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    q = prdata[7:0];
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20)
    begin
      err_total++;
      final_report();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] q);
    logic e;
    apb(1'b0, a, 8'h00, q, e);
  endtask
  task automatic wait_irq(output int n);
    n = 0;
    while (irq !== 1'b1 && n < 1000)
    begin
      @(posedge ref_clk);
      n++;
    end
    if (n >= 1000)
    begin
      err_total++;
      final_report();
    end
  endtask
  task automatic conv(input logic [9:0] v, input logic [7:0] st);
    int n;
    logic [7:0] q;
    level <= v;
    wr(8'h00, st);
    n = 0;
    q = 8'h00;
    while (q[7] !== 1'b1 && n < 100)
    begin
      rd(8'h00, q);
      n++;
    end
    check(16'(q[7]), 16'h0001, "complete flag set");
  endtask
  ////////////////////////////////////////
  initial
  begin
    logic [7:0] q;
    logic [7:0] h;
    logic [7:0] l;
    logic e;
    logic [2:0] p;
    logic [15:0] x;
    logic [9:0] v;
    int n;
    int d;
    repeat (20) @(posedge ref_clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
    rd(8'h00, q);
    check(q, 16'h001f, "status reset");
    rd(8'h0c, q);
    check(q, 16'h0000, "clock config reset");
    wr(8'h04, 8'ha5);
    rd(8'h04, q);
    check(q, 16'h0000, "result write ignored");
    apb(1'b0, 8'h10, 8'h00, q, e);
    check({e, q}, 16'h0100, "unmapped read");
    $display("register test done");
    for (int c = 0; c < 11; c++)
    begin
      lfsr = lfsr_next(lfsr);
      port_out <= lfsr[9:0];
      port_dir <= lfsr[15:6];
      pin_in <= ~lfsr[9:0];
      wr(8'h00, (c == 10) ? 8'h1f : 8'(c));
      repeat (4) @(posedge ref_clk);
      x = (c == 10) ? 16'h0000 : 16'h0001 << c;
      check(takeover, x, "taken pin");
      check(port_read, pin_in & ~x[9:0], "port read");
      check(pin_oe, port_dir & ~x[9:0], "pin enable");
      check(16'(pdown), 16'(c == 10), "power down");
      check(achan, (c == 10) ? 16'h001f : 16'(c), "channel");
    end
    $display("pin test done");
    wr(8'h00, 8'h43);
    wait_irq(n);
    for (int k = 0; k < 7; k++)
    begin
      p = (k == 6) ? 3'h0 : (k == 5) ? 3'h7 : 3'(k);
      d = (k == 6) ? 3 : (p[2] ? 16 : 1 << p);
      wr(8'h0c, {p, k != 6, 4'h0});
      wr(8'h00, 8'h43);
      repeat (8 * d) @(posedge ref_clk);
      // The first conversion is aborted and its result never used.
      wr(8'h00, 8'h43);
      wait_irq(n);
      check(16'(n >= 16 * d && n <= 17 * d + 6), 16'h0001,
        "conversion time");
      rd(8'h00, q);
      check(16'(q[7]), 16'h0000, "flag with irq enabled");
      rd(8'h08, q);
      @(posedge ref_clk);
      check(16'(irq), 16'h0000, "irq cleared by read");
    end
    $display("timing test done");
    for (int f = 0; f < 4; f++)
    begin
      for (int t = 0; t < 3; t++)
      begin
        lfsr = lfsr_next(lfsr);
        v = (t == 0) ? 10'h000 : (t == 1) ? 10'h3ff : lfsr[9:0];
        wr(8'h0c, {4'h1, 2'(f), 2'h0});
        conv(v, 8'h03);
        rd(8'h04, h);
        rd(8'h08, l);
        check({h, l}, fmt_exp(2'(f), v), "result");
        rd(8'h00, q);
        check(16'(q[7]), 16'h0000, "flag cleared");
      end
    end
    for (int f = 0; f < 4; f += 3)
    begin
      wr(8'h0c, {4'h1, 2'(f), 2'h0});
      conv(10'h155, 8'h03);
      rd(8'h04, h);
      conv(10'h2aa, 8'h03);
      rd(8'h08, l);
      x = fmt_exp(2'(f), (f == 3) ? 10'h2aa : 10'h155);
      check(l, x[7:0], "low after high read");
    end
    $display("format test done");
    wr(8'h0c, 8'h14);
    conv(10'h0f0, 8'h23);
    level <= 10'h30c;
    repeat (60) @(posedge ref_clk);
    rd(8'h04, h);
    rd(8'h08, l);
    check({h, l}, 16'h030c, "continuous overwrite");
    wr(8'h00, 8'h03);
    repeat (60) @(posedge ref_clk);
    rd(8'h04, h);
    rd(8'h08, l);
    level <= 10'h001;
    repeat (60) @(posedge ref_clk);
    rd(8'h00, q);
    check(16'(q[7]), 16'h0000, "conversions stopped");
    rd(8'h08, l);
    check(l, 16'h000c, "result kept");
    $display("continuous test done");
    // Power down before idling, as software would before wait mode.
    wr(8'h00, 8'h1f);
    final_report();
  end
endmodule
